// File: logic/csco_defines.vh
// Constants for the converter and system control instruction block.
// Assumes a 32-bit classic Wishbone register bus and the block's own opcode set.
`ifndef CSCO_DEFINES_VH
`define CSCO_DEFINES_VH

// Register byte offsets
`define CSCO_ADR_CMD 8'h00
`define CSCO_ADR_ACC 8'h04
`define CSCO_ADR_AUX 8'h08
`define CSCO_ADR_CTRL 8'h0C
`define CSCO_ADR_IRQC 8'h10
`define CSCO_ADR_STAT 8'h14
`define CSCO_ADR_PC 8'h18
`define CSCO_ADR_CMP 8'h1C

// Opcodes written to the command register
`define CSCO_OP_NOP 5'h00
`define CSCO_OP_MOVE_RES 5'h01
`define CSCO_OP_MOVE_LOW 5'h02
`define CSCO_OP_SET_CMP 5'h03
`define CSCO_OP_FETCH_CTRL 5'h04
`define CSCO_OP_WRITE_CTRL 5'h05
`define CSCO_OP_KICK 5'h06
`define CSCO_OP_SKIP_DONE 5'h07
`define CSCO_OP_ENTER_BACKUP 5'h08
`define CSCO_OP_ARM_BACKUP 5'h09
`define CSCO_OP_SKIP_WAKE 5'h0A
`define CSCO_OP_ARM_WDT_STOP 5'h0B
`define CSCO_OP_WDT_RESTART 5'h0C
`define CSCO_OP_SYS_RESET 5'h0D
`define CSCO_OP_CLR_UPT 5'h0E
`define CSCO_OP_SET_UPT 5'h0F
`define CSCO_OP_ARM_LVD 5'h10

// Field positions
`define CSCO_CTRL_MODE_BIT 3
`define CSCO_IRQC_DONE_SEL_BIT 2

// Status bit positions
`define CSCO_ST_DONE 0
`define CSCO_ST_WDF 1
`define CSCO_ST_WAKE 2
`define CSCO_ST_UPT 3
`define CSCO_ST_BACKUP 4
`define CSCO_ST_WDT_STOP 5
`define CSCO_ST_LVD 6
`define CSCO_ST_ARM_BK 7
`define CSCO_ST_ARM_WDT 8
`define CSCO_ST_SKIP 9

// Reset values and counter step
`define CSCO_RST_NIBBLE 4'h0
`define CSCO_RST_CMP 8'h00
`define CSCO_RST_PC 12'h000
`define CSCO_PC_STEP 12'h001

`endif

// File: logic/csco_sync.v
// Two flip-flop synchroniser for levels from outside the clock domain.
// Assumes the input is a slow level; pulses shorter than one clock may be lost.
`timescale 1ns/100ps
`default_nettype none
module csco_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  // First stage feeds only the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // csco_sync
`default_nettype wire

// File: logic/csco_flag.v
// Sticky flag set by hardware and cleared by an instruction.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module csco_flag (
  input wire clk_i,
  input wire rst_i,
  input wire set_i,
  input wire clr_i,
  output reg flag_o
);
  // Set wins so an event in the clearing cycle is kept
  always @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule // csco_flag
`default_nettype wire

// File: logic/csco_core.v
// Converter access and system control instruction executor with Wishbone slave.
// Assumes converter and watchdog signals on clk_i; wake pin is asynchronous.
`timescale 1ns/100ps
`default_nettype none
`include "csco_defines.vh"
// Operation
// - Conversion mode: result 9-6 to aux, 5-2 acc
// - Comparator mode: compare 7-4 aux, 3-0 acc
// - Low move: result 1-0 to acc 3-2
// - Comparator mode: aux, acc load compare register
// - Conversion mode: compare load acts as nop
// - Mode bit is control register bit 3
// - Fetch control register into accumulator
// - Write accumulator into control register
// - Kick clears done flag, starts selected operation
// - Done skip skips and clears when set
// - Select bit set makes done skip nop
// - Nop advances counter by one only
// - Backup entry works only after arming
// - Arming covers only the very next instruction
// - Wake skip skips on flag, keeps it
// - Watchdog stops only on arm then restart
// - Restart clears expiry flag, skips when set
// - Clear upper reference enable flag
// - Set upper reference enable flag
// - Arm voltage detect for backup, high grade
module csco_core #(
  parameter HIGH_GRADE = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire [9:0] ad_result_i,
  input wire conv_done_i,
  input wire wdt_expire_i,
  input wire wake_pin_i,
  output reg adc_start_o,
  output reg cmp_start_o,
  output reg wdt_restart_o,
  output reg wdt_stop_o,
  output reg backup_o,
  output wire lvd_enable_o,
  output reg sys_reset_o
);
  reg [3:0] acc_r;
  reg [3:0] aux_r;
  reg [3:0] ctrl_r;
  reg [3:0] irqc_r;
  reg [7:0] cmp_r;
  reg [11:0] pc_r;
  reg upt_r;
  reg lvd_arm_r;
  reg arm_bk_r;
  reg arm_wdt_r;
  reg skip_r;
  reg wake_flag_r;
  reg software_system_reset_r;
  wire loc_rst;
  wire wake_s;
  wire bus_req;
  wire wr_en;
  wire cmd_go;
  wire [4:0] op;
  wire mode_cmp;
  wire done_sel;
  wire done_flag;
  wire wdf_flag;
  wire exec;
  reg done_clr;
  reg wdf_clr;
  reg [31:0] rd_nxt;
  wire [9:0] status;

  // Software reset reuses the register reset path; bus ack and wake sync stay on rst_i
  assign loc_rst = rst_i | software_system_reset_r;
  assign bus_req = cyc_i & stb_i;
  // Writes land at the edge where ack is seen by the master
  assign wr_en = bus_req & we_i & ack_o & sel_i[0];
  // Backup stops instruction execution until wake
  assign cmd_go = wr_en && (adr_i == `CSCO_ADR_CMD) && !backup_o;
  assign op = dat_i[4:0];
  assign mode_cmp = ctrl_r[`CSCO_CTRL_MODE_BIT];
  assign done_sel = irqc_r[`CSCO_IRQC_DONE_SEL_BIT];
  // A skipped instruction is consumed with no effect
  assign exec = cmd_go & ~skip_r;
  // Armed level reaches the pin only while in backup
  assign lvd_enable_o = lvd_arm_r & backup_o;

  // Wake pin is asynchronous; only the second flop is read
  csco_sync #(
    .W(1)
  ) u_wake_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(wake_pin_i),
    .q_o(wake_s)
  );

  // Event inputs share clk_i, so no synchroniser here
  csco_flag u_done_flag (
    .clk_i(clk_i),
    .rst_i(loc_rst),
    .set_i(conv_done_i),
    .clr_i(done_clr),
    .flag_o(done_flag)
  );

  csco_flag u_wdf_flag (
    .clk_i(clk_i),
    .rst_i(loc_rst),
    .set_i(wdt_expire_i),
    .clr_i(wdf_clr),
    .flag_o(wdf_flag)
  );

  // Flag clears from instructions
  always @* begin
    done_clr = 1'b0;
    wdf_clr = 1'b0;
    if (exec) begin
      case (op)
        `CSCO_OP_KICK: begin
          done_clr = 1'b1;
        end
        `CSCO_OP_SKIP_DONE: begin
          done_clr = ~done_sel & done_flag;
        end
        `CSCO_OP_WDT_RESTART: begin
          wdf_clr = 1'b1;
        end
        default: begin
          done_clr = 1'b0;
          wdf_clr = 1'b0;
        end
      endcase
    end
  end

  // Software reset pulse lasts one cycle; its register is reset only by the external reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      software_system_reset_r <= 1'b0;
      sys_reset_o <= 1'b0;
    end else begin
      software_system_reset_r <= exec && (op == `CSCO_OP_SYS_RESET);
      sys_reset_o <= exec && (op == `CSCO_OP_SYS_RESET);
    end
  end

  // Instruction execution
  always @(posedge clk_i) begin
    if (loc_rst) begin
      acc_r <= `CSCO_RST_NIBBLE;
      aux_r <= `CSCO_RST_NIBBLE;
      ctrl_r <= `CSCO_RST_NIBBLE;
      irqc_r <= `CSCO_RST_NIBBLE;
      cmp_r <= `CSCO_RST_CMP;
      pc_r <= `CSCO_RST_PC;
      upt_r <= 1'b0;
      lvd_arm_r <= 1'b0;
      arm_bk_r <= 1'b0;
      arm_wdt_r <= 1'b0;
      skip_r <= 1'b0;
      wake_flag_r <= 1'b0;
      backup_o <= 1'b0;
      wdt_stop_o <= 1'b0;
      adc_start_o <= 1'b0;
      cmp_start_o <= 1'b0;
      wdt_restart_o <= 1'b0;
    end else begin
      adc_start_o <= 1'b0;
      cmp_start_o <= 1'b0;
      wdt_restart_o <= 1'b0;
      // Leaving backup on a wake level records the return
      if (backup_o && wake_s) begin
        backup_o <= 1'b0;
        wake_flag_r <= 1'b1;
      end
      // Direct software access to the data registers
      // Still acked in backup, so the bus never hangs
      if (wr_en && !backup_o) begin
        case (adr_i)
          `CSCO_ADR_ACC: begin
            acc_r <= dat_i[3:0];
          end
          `CSCO_ADR_AUX: begin
            aux_r <= dat_i[3:0];
          end
          `CSCO_ADR_CTRL: begin
            ctrl_r <= dat_i[3:0];
          end
          `CSCO_ADR_IRQC: begin
            irqc_r <= dat_i[3:0];
          end
          default: begin
            acc_r <= acc_r;
          end
        endcase
      end
      if (cmd_go) begin
        pc_r <= pc_r + `CSCO_PC_STEP;
        // Arming lasts one instruction, skipped or not
        arm_bk_r <= 1'b0;
        arm_wdt_r <= 1'b0;
        skip_r <= 1'b0;
      end
      if (exec) begin
        case (op)
          `CSCO_OP_MOVE_RES: begin
            if (mode_cmp) begin
              aux_r <= cmp_r[7:4];
              acc_r <= cmp_r[3:0];
            end else begin
              aux_r <= ad_result_i[9:6];
              acc_r <= ad_result_i[5:2];
            end
          end
          `CSCO_OP_MOVE_LOW: begin
            acc_r <= {ad_result_i[1:0], 2'b00};
          end
          `CSCO_OP_SET_CMP: begin
            // Conversion mode leaves the compare value alone
            if (mode_cmp) begin
              cmp_r <= {aux_r, acc_r};
            end
          end
          `CSCO_OP_FETCH_CTRL: begin
            acc_r <= ctrl_r;
          end
          `CSCO_OP_WRITE_CTRL: begin
            ctrl_r <= acc_r;
          end
          `CSCO_OP_KICK: begin
            adc_start_o <= ~mode_cmp;
            cmp_start_o <= mode_cmp;
          end
          `CSCO_OP_SKIP_DONE: begin
            skip_r <= ~done_sel & done_flag;
          end
          `CSCO_OP_ENTER_BACKUP: begin
            if (arm_bk_r) begin
              backup_o <= 1'b1;
            end
          end
          `CSCO_OP_ARM_BACKUP: begin
            arm_bk_r <= 1'b1;
          end
          `CSCO_OP_SKIP_WAKE: begin
            skip_r <= wake_flag_r;
          end
          `CSCO_OP_ARM_WDT_STOP: begin
            arm_wdt_r <= 1'b1;
          end
          `CSCO_OP_WDT_RESTART: begin
            wdt_restart_o <= 1'b1;
            skip_r <= wdf_flag;
            if (arm_wdt_r) begin
              wdt_stop_o <= 1'b1;
            end
          end
          `CSCO_OP_CLR_UPT: begin
            upt_r <= 1'b0;
          end
          `CSCO_OP_SET_UPT: begin
            upt_r <= 1'b1;
          end
          `CSCO_OP_ARM_LVD: begin
            // Low grade parts treat this opcode as a nop
            if (HIGH_GRADE != 0) begin
              lvd_arm_r <= 1'b1;
            end
          end
          default: begin
            skip_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Status word: flags first, then arming and skip state
  assign status = {skip_r, arm_wdt_r, arm_bk_r, lvd_arm_r, wdt_stop_o,
                   backup_o, upt_r, wake_flag_r, wdf_flag, done_flag};

  // Read mux; unmapped offsets read zero
  always @* begin
    rd_nxt = 32'h00000000;
    case (adr_i)
      `CSCO_ADR_CMD: begin
        rd_nxt = 32'h00000000;
      end
      `CSCO_ADR_ACC: begin
        rd_nxt[3:0] = acc_r;
      end
      `CSCO_ADR_AUX: begin
        rd_nxt[3:0] = aux_r;
      end
      `CSCO_ADR_CTRL: begin
        rd_nxt[3:0] = ctrl_r;
      end
      `CSCO_ADR_IRQC: begin
        rd_nxt[3:0] = irqc_r;
      end
      `CSCO_ADR_STAT: begin
        rd_nxt[9:0] = status;
      end
      `CSCO_ADR_PC: begin
        rd_nxt[11:0] = pc_r;
      end
      `CSCO_ADR_CMP: begin
        rd_nxt[7:0] = cmp_r;
      end
      default: begin
        rd_nxt = 32'h00000000;
      end
    endcase
  end

  // One wait state; ack drops the cycle after it was given
  // Read data is latched in the wait state, so it stands with ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req & ~ack_o;
      if (bus_req && !ack_o && !we_i) begin
        dat_o <= rd_nxt;
      end
    end
  end
endmodule // csco_core
`default_nettype wire

// File: test/csco_sva.sv
// Port checker for the converter and system control block.
// Assumes the defines header on the include path and the bind below.
`timescale 1ns/100ps
`default_nettype none
`include "csco_defines.vh"
module csco_sva (
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_i,
  input wire [3:0] sel_i,
  input wire we_i,
  input wire cyc_i,
  input wire stb_i,
  input wire ack_o,
  input wire adc_start_o,
  input wire cmp_start_o,
  input wire wdt_restart_o,
  input wire wdt_stop_o,
  input wire backup_o,
  input wire lvd_enable_o,
  input wire sys_reset_o
);
  // Opcode written in the previous cycle, bit 5 marks valid
  reg [5:0] last_r;
  wire cmd_w = ack_o && cyc_i && stb_i && we_i && sel_i[0] && adr_i == `CSCO_ADR_CMD;
  always @(posedge clk_i) begin
    last_r <= (cmd_w && !rst_i) ? {1'b1, dat_i[4:0]} : 6'h00;
  end
  // Voltage detect armed at least once since reset
  reg lvd_seen_r;
  always @(posedge clk_i) begin
    if (rst_i) lvd_seen_r <= 1'b0;
    else if (cmd_w && dat_i[4:0] == `CSCO_OP_ARM_LVD) lvd_seen_r <= 1'b1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_ans;
    ack_o ##1 !ack_o;
  endsequence
  chk_ack_answer: assert property (s_req |=> s_ans) else $error("ack not one cycle later");
  chk_start_cause: assert property (adc_start_o || cmp_start_o |-> last_r == {1'b1, `CSCO_OP_KICK})
    else $error("start without kick");
  chk_start_excl: assert property (!(adc_start_o && cmp_start_o))
    else $error("both starts");
  chk_restart_cause: assert property (wdt_restart_o |-> last_r == {1'b1, `CSCO_OP_WDT_RESTART})
    else $error("restart without opcode");
  chk_stop_cause: assert property ($rose(wdt_stop_o) |-> last_r == {1'b1, `CSCO_OP_WDT_RESTART})
    else $error("watchdog stop without restart");
  chk_backup_cause: assert property ($rose(backup_o) |-> last_r == {1'b1, `CSCO_OP_ENTER_BACKUP})
    else $error("backup without entry");
  chk_lvd_gate: assert property (lvd_enable_o |-> backup_o && lvd_seen_r)
    else $error("lvd outside backup");
  chk_sysrst_pulse: assert property (sys_reset_o |=> !sys_reset_o)
    else $error("reset pulse too long");
endmodule // csco_sva
bind csco_core csco_sva i_sva (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i, .stb_i,
  .ack_o, .adc_start_o, .cmp_start_o, .wdt_restart_o, .wdt_stop_o, .backup_o, .lvd_enable_o,
  .sys_reset_o);
`default_nettype wire

// File: test/csco_conv_model.sv
// Converter model: answers a start with a done pulse three cycles on.
// Assumes start pulses on clk_i; result is garbage while converting.
`timescale 1ns/100ps
`default_nettype none
module csco_conv_model #(
  parameter [9:0] RES = 10'h2B5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic [9:0] ad_result_o,
  output logic conv_done_o
);
  logic [2:0] cnt_r;
  always @(posedge clk_i) begin
    if (rst_i) cnt_r <= 3'h0;
    else if (start_i) cnt_r <= 3'h3;
    else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
  end
  // Inverted value mid-conversion so an early read shows
  assign ad_result_o = (cnt_r != 3'h0) ? ~RES : RES;
  assign conv_done_o = cnt_r == 3'h1;
endmodule // csco_conv_model
`default_nettype wire

// File: test/tb.sv
// Bench: Wishbone tasks drive opcodes and check results.
// Assumes the converter model on the far side and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`include "csco_defines.vh"
module tb;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, wake = 0, wdx = 0, seen_rst = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, q, p, dat_o;
  logic ack_o, adc_s, cmp_s, wrs, wstop, bk, lvd, software_system_reset, done;
  logic [9:0] res;
  int miscompares = 0, total_checks = 0, cyc_n = 0;
  int n_adc = 0, n_cmp = 0, n_wrs = 0;
  always #25 clk_i = ~clk_i;
  csco_core i_dut (.clk_i, .rst_i, .adr_i(adr), .dat_i(dat), .sel_i(sel), .we_i(we),
    .cyc_i(cyc), .stb_i(stb), .dat_o, .ack_o, .ad_result_i(res), .conv_done_i(done),
    .wdt_expire_i(wdx), .wake_pin_i(wake), .adc_start_o(adc_s), .cmp_start_o(cmp_s),
    .wdt_restart_o(wrs), .wdt_stop_o(wstop), .backup_o(bk), .lvd_enable_o(lvd),
    .sys_reset_o(software_system_reset));
  csco_conv_model i_far (.clk_i, .rst_i, .start_i(adc_s | cmp_s), .ad_result_o(res),
    .conv_done_o(done));
  task finish_test;
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task chk1(input string n, input logic s, input logic e);
    chk(n, {31'h0, s}, {31'h0, e});
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    q = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask
  task op(input logic [4:0] o);
    xfer(1, `CSCO_ADR_CMD, {27'h0, o});
  endtask
  task st(input int b, input logic e);
    xfer(0, `CSCO_ADR_STAT, 32'h0);
    chk1("stat", q[b], e);
  endtask
  always @(posedge clk_i) begin
    if (software_system_reset === 1'b1) seen_rst <= 1;
    if (adc_s === 1'b1) n_adc++;
    if (cmp_s === 1'b1) n_cmp++;
    if (wrs === 1'b1) n_wrs++;
    cyc_n++;
    if (cyc_n == 5000) begin
      miscompares++;
      finish_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    xfer(0, `CSCO_ADR_PC, 0); chk("pc", q, 0);
    xfer(1, `CSCO_ADR_CTRL, 0); op(`CSCO_OP_MOVE_RES);
    xfer(0, `CSCO_ADR_AUX, 0); chk("aux", q, 32'hA);
    xfer(0, `CSCO_ADR_ACC, 0); chk("acc", q, 32'hD);
    xfer(1, `CSCO_ADR_ACC, 32'hF); op(`CSCO_OP_MOVE_LOW);
    xfer(0, `CSCO_ADR_ACC, 0); chk("acc", q, 32'h4);
    xfer(1, `CSCO_ADR_ACC, 5); xfer(1, `CSCO_ADR_AUX, 9); xfer(1, `CSCO_ADR_CTRL, 8);
    op(`CSCO_OP_SET_CMP); xfer(0, `CSCO_ADR_CMP, 0); chk("cmp", q, 32'h95);
    xfer(1, `CSCO_ADR_ACC, 0); xfer(1, `CSCO_ADR_AUX, 0); op(`CSCO_OP_MOVE_RES);
    xfer(0, `CSCO_ADR_AUX, 0); chk("aux", q, 32'h9);
    xfer(0, `CSCO_ADR_ACC, 0); chk("acc", q, 32'h5);
    op(`CSCO_OP_FETCH_CTRL); xfer(0, `CSCO_ADR_ACC, 0); chk("acc", q, 32'h8);
    xfer(1, `CSCO_ADR_ACC, 3); op(`CSCO_OP_WRITE_CTRL);
    xfer(0, `CSCO_ADR_CTRL, 0); chk("ctrl", q, 32'h3);
    xfer(0, `CSCO_ADR_PC, 0); p = q;
    op(`CSCO_OP_SET_CMP); xfer(0, `CSCO_ADR_CMP, 0); chk("cmp", q, 32'h95);
    op(`CSCO_OP_NOP); xfer(0, `CSCO_ADR_PC, 0); chk("pc", q, p + 2);
    xfer(0, `CSCO_ADR_ACC, 0); chk("acc", q, 32'h3);
    op(`CSCO_OP_KICK); repeat (6) @(posedge clk_i); op(`CSCO_OP_KICK);
    st(`CSCO_ST_DONE, 0);
    repeat (4) @(posedge clk_i); st(`CSCO_ST_DONE, 1);
    xfer(1, `CSCO_ADR_IRQC, 0); op(`CSCO_OP_SKIP_DONE); op(`CSCO_OP_SET_UPT);
    st(`CSCO_ST_UPT, 0);
    st(`CSCO_ST_DONE, 0);
    op(`CSCO_OP_KICK); repeat (8) @(posedge clk_i);
    xfer(1, `CSCO_ADR_IRQC, 4); op(`CSCO_OP_SKIP_DONE); op(`CSCO_OP_SET_UPT);
    st(`CSCO_ST_UPT, 1);
    st(`CSCO_ST_DONE, 1);
    op(`CSCO_OP_CLR_UPT); st(`CSCO_ST_UPT, 0);
    wdx <= 1; @(posedge clk_i); wdx <= 0;
    op(`CSCO_OP_WDT_RESTART); op(`CSCO_OP_SET_UPT);
    st(`CSCO_ST_WDF, 0);
    st(`CSCO_ST_UPT, 0);
    op(`CSCO_OP_ARM_WDT_STOP); op(`CSCO_OP_NOP); op(`CSCO_OP_WDT_RESTART);
    chk1("wdt_stop", wstop, 0);
    op(`CSCO_OP_ARM_WDT_STOP); op(`CSCO_OP_WDT_RESTART); chk1("wdt_stop", wstop, 1);
    op(`CSCO_OP_ENTER_BACKUP); op(`CSCO_OP_ARM_BACKUP); op(`CSCO_OP_NOP);
    op(`CSCO_OP_ENTER_BACKUP); chk1("backup", bk, 0);
    op(`CSCO_OP_ARM_LVD); op(`CSCO_OP_ARM_BACKUP); op(`CSCO_OP_ENTER_BACKUP);
    chk1("backup", bk, 1);
    chk1("lvd", lvd, 1);
    xfer(1, `CSCO_ADR_ACC, 32'h7);
    wake <= 1; repeat (6) @(posedge clk_i); wake <= 0;
    chk1("backup", bk, 0); chk1("lvd", lvd, 0);
    op(`CSCO_OP_SKIP_WAKE); op(`CSCO_OP_SET_UPT); st(`CSCO_ST_UPT, 0);
    st(`CSCO_ST_WAKE, 1);
    xfer(1, `CSCO_ADR_CTRL, 8); op(`CSCO_OP_KICK);
    xfer(0, `CSCO_ADR_ACC, 0); chk("acc", q, 32'h3);
    chk("adc_starts", n_adc, 3);
    chk("cmp_starts", n_cmp, 1);
    chk("restarts", n_wrs, 3);
    op(`CSCO_OP_SYS_RESET); repeat (3) @(posedge clk_i);
    chk1("sys_reset", seen_rst, 1);
    chk1("wdt_stop", wstop, 0);
    xfer(0, `CSCO_ADR_PC, 0); chk("pc", q, 0);
    xfer(0, `CSCO_ADR_CTRL, 0); chk("ctrl", q, 0);
    xfer(0, 8'h20, 0); chk("unmapped", q, 0);
    finish_test;
  end
endmodule // tb
`default_nettype wire
